// *** ibd_device.sv ***
// device end of the instrument bus: handshakes, addressing and commands
`include "ibd_consts.svh"
module ibd_device (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [4:0] primaryAddr, // own primary address
   input wire logic [7:0] dioIn, // data lines, true = 1
   output logic [7:0] dioOut,
   output logic dioOe,
   input wire logic atnIn, // attention, true = 1
   input wire logic ifcIn, // interface clear
   input wire logic renIn, // remote enable
   input wire logic davIn,
   output logic davOut,
   output logic davOe,
   input wire logic nrfdIn,
   output logic nrfdOut,
   output logic nrfdOe,
   input wire logic ndacIn,
   output logic ndacOut,
   output logic ndacOe,
   input wire logic eoiIn,
   output logic eoiOut,
   output logic eoiOe,
   output logic srqOut,
   output logic srqOe,
   input wire logic svcReq, // user asks for service
   input wire logic [7:0] statusByte, // user status, bit 6 replaced
   input wire logic [7:0] txData, // user bytes to send
   input wire logic txEnd,
   input wire logic txValid,
   output logic txReady,
   output logic [7:0] rxData, // received data bytes
   output logic rxEnd,
   output logic rxValid,
   input wire logic rxReady,
   output logic listenActive,
   output logic talkActive,
   output logic remoteMode,
   output logic lockoutMode,
   output logic devClear, // one-cycle pulse
   output logic trigger // one-cycle pulse
);
   // ---------------------------------------------------------------
   // acceptor handshake
   // ---------------------------------------------------------------
   ibd_pkg::ibd_acc_e accState_r;
   logic [7:0] accByte_r; // latched byte
   logic accAtn_r; // attention at latch time
   logic accEoi_r;
   logic accStrobe_r; // one-cycle byte taken
   logic rxInReady; // buffer can take a data byte
   logic accEnable; // we take part as acceptor
   assign accEnable = atnIn || listenActive;
   // nrfd released in wait for a command byte, or for a data byte only when we can store it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         accState_r <= ibd_pkg::AH_IDLE;
         accByte_r <= 8'h00;
         accAtn_r <= 1'b0;
         accEoi_r <= 1'b0;
         accStrobe_r <= 1'b0;
      end else begin
         accStrobe_r <= 1'b0;
         case (accState_r)
            ibd_pkg::AH_IDLE: begin
               // a talker still takes commands under attention, or it could never be unaddressed
               if (accEnable) begin
                  accState_r <= ibd_pkg::AH_WAIT;
               end
            end
            ibd_pkg::AH_WAIT: begin
               // latch on data valid, then drop not-accepted
               if (!accEnable) begin
                  accState_r <= ibd_pkg::AH_IDLE;
               end else if (davIn && (atnIn || rxInReady)) begin
                  accByte_r <= dioIn;
                  accAtn_r <= atnIn;
                  accEoi_r <= eoiIn;
                  accStrobe_r <= 1'b1;
                  accState_r <= ibd_pkg::AH_HOLD;
               end
            end
            ibd_pkg::AH_HOLD: begin
               if (!davIn) begin
                  accState_r <= ibd_pkg::AH_IDLE;
               end
            end
            default: begin
               accState_r <= ibd_pkg::AH_IDLE;
            end
         endcase
      end
   end
   // handshake lines: nrfd held unless waiting, ndac held until latched
   assign nrfdOe = accEnable && (accState_r != ibd_pkg::AH_WAIT || (!atnIn && !rxInReady));
   assign nrfdOut = nrfdOe;
   assign ndacOe = accEnable && (accState_r != ibd_pkg::AH_HOLD);
   assign ndacOut = ndacOe;
   // ---------------------------------------------------------------
   // command decode
   // ---------------------------------------------------------------
   logic [6:0] cmd;
   logic isCmd;
   assign cmd = accByte_r[6:0] & `IBD_CMD_BITS;
   assign isCmd = accStrobe_r && accAtn_r;
   // compare a byte to an address group entry
   function automatic logic addrHit(input logic [6:0] b, input logic [7:0] base, input logic [4:0] pa);
      addrHit = ({1'b0, b} == (base | {3'h0, pa}));
   endfunction : addrHit
   logic myListen;
   logic myTalk;
   logic otherTalk;
   assign myListen = isCmd && addrHit(cmd, `IBD_LAG_BASE, primaryAddr);
   assign myTalk = isCmd && addrHit(cmd, `IBD_TAG_BASE, primaryAddr);
   assign otherTalk = isCmd && (({1'b0, cmd} & `IBD_GRP_MASK) == `IBD_TAG_BASE) && !myTalk;
   // secondary group 60-7f falls through every compare
   logic cmdUnl;
   logic cmdUnt;
   logic addrCmd; // addressed command allowed
   assign cmdUnl = isCmd && ({1'b0, cmd} == `IBD_CMD_UNL);
   assign cmdUnt = isCmd && ({1'b0, cmd} == `IBD_CMD_UNT);
   assign addrCmd = isCmd && listenActive;
   // ---------------------------------------------------------------
   // listener and talker addressing
   // ---------------------------------------------------------------
   logic listen_r;
   logic talk_r;
   assign listenActive = listen_r;
   assign talkActive = talk_r;
   // listener state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         listen_r <= 1'b0;
      end else if (ifcIn) begin
         listen_r <= 1'b0;
      end else if (myListen) begin
         listen_r <= 1'b1;
      end else if (cmdUnl || myTalk) begin
         listen_r <= 1'b0;
      end
   end
   // talker state, dropped on any listen address of ours
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         talk_r <= 1'b0;
      end else if (ifcIn) begin
         talk_r <= 1'b0;
      end else if (myTalk) begin
         talk_r <= 1'b1;
      end else if (cmdUnt || otherTalk || myListen) begin
         talk_r <= 1'b0;
      end
   end
   // ---------------------------------------------------------------
   // serial poll, clear, trigger, remote and local
   // ---------------------------------------------------------------
   logic spoll_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         spoll_r <= 1'b0;
      end else if (ifcIn || (isCmd && {1'b0, cmd} == `IBD_CMD_SPD)) begin
         spoll_r <= 1'b0;
      end else if (isCmd && {1'b0, cmd} == `IBD_CMD_SPE) begin
         spoll_r <= 1'b1;
      end
   end
   // clear pulse on universal clear or addressed selective clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         devClear <= 1'b0;
         trigger <= 1'b0;
      end else begin
         devClear <= (isCmd && {1'b0, cmd} == `IBD_CMD_DCL) || (addrCmd && {1'b0, cmd} == `IBD_CMD_SDC);
         trigger <= addrCmd && ({1'b0, cmd} == `IBD_CMD_GET);
      end
   end
   // remote on listen address while remote enable is true
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         remoteMode <= 1'b0;
         lockoutMode <= 1'b0;
      end else if (!renIn) begin
         remoteMode <= 1'b0;
         lockoutMode <= 1'b0;
      end else begin
         if (myListen) begin
            remoteMode <= 1'b1;
         end else if (addrCmd && {1'b0, cmd} == `IBD_CMD_GTL) begin
            remoteMode <= 1'b0;
         end
         if (isCmd && {1'b0, cmd} == `IBD_CMD_LLO) begin
            lockoutMode <= 1'b1;
         end
      end
   end
   // ---------------------------------------------------------------
   // service request and data buffer
   // ---------------------------------------------------------------
   assign srqOe = svcReq;
   assign srqOut = svcReq;
   ibd_buf2 u_rxBuf (
      .clk(clk),
      .rst_n(rst_n),
      .inValid(accStrobe_r && !accAtn_r && listen_r),
      .inReady(rxInReady),
      .inData(accByte_r),
      .inEnd(accEoi_r),
      .outValid(rxValid),
      .outReady(rxReady),
      .outData(rxData),
      .outEnd(rxEnd)
   );
   // ---------------------------------------------------------------
   // source handshake
   // ---------------------------------------------------------------
   ibd_pkg::ibd_src_e srcState_r;
   logic [7:0] srcByte_r;
   logic srcEoi_r;
   logic srcOn; // talker allowed to send
   assign srcOn = talk_r && !atnIn && !ifcIn;
   assign txReady = srcOn && (srcState_r == ibd_pkg::SH_IDLE);
   // one byte per data valid cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         srcState_r <= ibd_pkg::SH_IDLE;
         srcByte_r <= 8'h00;
         srcEoi_r <= 1'b0;
      end else if (!srcOn) begin
         srcState_r <= ibd_pkg::SH_IDLE;
      end else begin
         case (srcState_r)
            ibd_pkg::SH_IDLE: begin
               if (spoll_r) begin
                  srcByte_r <= statusByte;
                  srcByte_r[`IBD_RQS_BIT] <= svcReq;
                  srcEoi_r <= 1'b0;
                  srcState_r <= ibd_pkg::SH_SETL;
               end else if (txValid) begin
                  srcByte_r <= txData;
                  srcEoi_r <= txEnd;
                  srcState_r <= ibd_pkg::SH_SETL;
               end
            end
            ibd_pkg::SH_SETL: begin
               if (!nrfdIn) begin
                  srcState_r <= ibd_pkg::SH_DAV;
               end
            end
            ibd_pkg::SH_DAV: begin
               if (!ndacIn) begin
                  srcState_r <= ibd_pkg::SH_DONE;
               end
            end
            ibd_pkg::SH_DONE: begin
               if (ndacIn && !spoll_r) begin
                  srcState_r <= ibd_pkg::SH_IDLE;
               end
            end
            default: begin
               srcState_r <= ibd_pkg::SH_IDLE;
            end
         endcase
      end
   end
   assign dioOe = srcOn && (srcState_r != ibd_pkg::SH_IDLE);
   assign dioOut = dioOe ? srcByte_r : 8'h00;
   assign davOe = srcOn && (srcState_r == ibd_pkg::SH_DAV);
   assign davOut = davOe;
   assign eoiOe = dioOe && srcEoi_r;
   assign eoiOut = eoiOe;
   // attention, clear and remote lines have no driver here
endmodule : ibd_device

// *** ibd_consts.svh ***
// constants for the instrument bus device interface
`ifndef IBD_CONSTS_SVH
`define IBD_CONSTS_SVH
// ---------------------------------------------------------------
// multiline command codes
// ---------------------------------------------------------------
`define IBD_CMD_GTL 8'h01
`define IBD_CMD_SDC 8'h04
`define IBD_CMD_GET 8'h08
`define IBD_CMD_LLO 8'h11
`define IBD_CMD_DCL 8'h14
`define IBD_CMD_SPE 8'h18
`define IBD_CMD_SPD 8'h19
`define IBD_CMD_UNL 8'h3f
`define IBD_CMD_UNT 8'h5f
// ---------------------------------------------------------------
// address groups
// ---------------------------------------------------------------
`define IBD_LAG_BASE 8'h20
`define IBD_TAG_BASE 8'h40
`define IBD_GRP_MASK 8'h60
`define IBD_ADR_MASK 8'h1f
`define IBD_CMD_BITS 7'h7f
// ---------------------------------------------------------------
// status byte layout and reset values
// ---------------------------------------------------------------
`define IBD_RQS_BIT 6
`define IBD_PAD_RST 5'h10
`define IBD_CNT_ONE 2'h1
`define IBD_CNT_TWO 2'h2
`define IBD_CNT_ZERO 2'h0
`endif

// *** ibd_pkg.sv ***
// types for the instrument bus device interface
package ibd_pkg;
   // acceptor handshake states
   typedef enum logic [1:0] {
      AH_IDLE = 2'b00,
      AH_WAIT = 2'b01,
      AH_HOLD = 2'b10
   } ibd_acc_e;
   // source handshake states
   typedef enum logic [1:0] {
      SH_IDLE = 2'b00,
      SH_SETL = 2'b01,
      SH_DAV = 2'b10,
      SH_DONE = 2'b11
   } ibd_src_e;
endpackage : ibd_pkg

// *** ibd_buf2.sv ***
// two-entry buffer with valid and ready on both sides
`include "ibd_consts.svh"
module ibd_buf2 (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic inValid,
   output logic inReady,
   input wire logic [7:0] inData,
   input wire logic inEnd,
   output logic outValid,
   input wire logic outReady,
   output logic [7:0] outData,
   output logic outEnd
);
   logic [8:0] mem_r [0:1]; // storage, end flag on top
   logic wrPtr_r; // write slot
   logic rdPtr_r; // read slot
   logic [1:0] cnt_r; // occupancy
   logic push;
   logic pop;
   assign inReady = (cnt_r != `IBD_CNT_TWO);
   assign outValid = (cnt_r != `IBD_CNT_ZERO);
   assign push = inValid && inReady;
   assign pop = outValid && outReady;
   // read data from the head register
   assign outData = mem_r[rdPtr_r][7:0];
   assign outEnd = mem_r[rdPtr_r][8];
   // storage and pointers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_r[0] <= 9'h000;
         mem_r[1] <= 9'h000;
         wrPtr_r <= 1'b0;
         rdPtr_r <= 1'b0;
      end else begin
         if (push) begin
            mem_r[wrPtr_r] <= {inEnd, inData};
            wrPtr_r <= ~wrPtr_r;
         end
         if (pop) begin
            rdPtr_r <= ~rdPtr_r;
         end
      end
   end
   // occupancy count
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= `IBD_CNT_ZERO;
      end else if (push && !pop) begin
         cnt_r <= cnt_r + `IBD_CNT_ONE;
      end else if (pop && !push) begin
         cnt_r <= cnt_r - `IBD_CNT_ONE;
      end
   end
endmodule : ibd_buf2

// *** ibd_device_sva.sv ***
// assertion checker for the device end of the instrument bus
module ibd_device_sva (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic atnIn,
   input wire logic ifcIn,
   input wire logic renIn,
   input wire logic eoiIn,
   input wire logic davIn,
   input wire logic nrfdIn,
   input wire logic svcReq,
   input wire logic dioOe,
   input wire logic davOe,
   input wire logic ndacOe,
   input wire logic srqOe,
   input wire logic listenActive,
   input wire logic talkActive,
   input wire logic remoteMode,
   input wire logic lockoutMode,
   input wire logic devClear,
   input wire logic trigger
);
   // one clock domain, so clock and reset are given once
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // ----
   // bus drive and handshake
   // ----
   talk_drive_a: assert property (dioOe |-> talkActive)
      else $error("data lines driven while not talker");
   dav_order_a: assert property ($rose(davOe) |-> !$past(nrfdIn))
      else $error("data valid raised before ready");
   ndac_order_a: assert property ($fell(ndacOe) && atnIn |-> $past(davIn))
      else $error("accepted without data valid");
   no_ppoll_a: assert property (atnIn && eoiIn && !talkActive |-> !dioOe)
      else $error("parallel poll answered");
   srq_raise_a: assert property ($rose(svcReq) |-> ##[1:3] srqOe)
      else $error("service request not raised");
   // ----
   // addressing, modes and command pulses
   // ----
   addr_excl_a: assert property (!(listenActive && talkActive))
      else $error("listener and talker at once");
   ifc_idle_a: assert property (ifcIn |-> ##[1:3] (!listenActive && !talkActive))
      else $error("interface clear left device addressed");
   ren_drop_a: assert property ($fell(renIn) |-> ##[1:3] (!remoteMode && !lockoutMode))
      else $error("remote kept without remote enable");
   clr_cause_a: assert property (devClear |=> !devClear && ($past(atnIn, 3) || $past(atnIn, 4)))
      else $error("bad clear pulse");
   trig_cause_a: assert property (trigger |=> !trigger && ($past(atnIn, 3) || $past(atnIn, 4)))
      else $error("bad trigger pulse");
endmodule : ibd_device_sva
bind ibd_device ibd_device_sva u_sva (.clk, .rst_n, .atnIn, .ifcIn, .renIn, .eoiIn, .davIn, .nrfdIn, .svcReq,
   .dioOe, .davOe, .ndacOe, .srqOe, .listenActive, .talkActive, .remoteMode, .lockoutMode, .devClear, .trigger);

// *** ibd_ctl_model.sv ***
// controller model standing on the far side of the instrument bus
module ibd_ctl_model (
   input wire logic clk,
   input wire logic nrfdIn,
   input wire logic ndacIn,
   input wire logic davIn,
   output logic atn,
   output logic dav,
   output logic eoi,
   output logic [7:0] dio,
   output logic nrfd,
   output logic ndac
);
   timeunit 1ns;
   timeprecision 100ps;
   int lag = 0; // extra cycles, slow partner
   // ----
   // idle bus: all lines released
   // ----
   initial begin
      atn = 1'b0;
      dav = 1'b0;
      eoi = 1'b0;
      dio = 8'h00;
      nrfd = 1'b0;
      ndac = 1'b0;
   end
   // source one byte; attention held as given
   task automatic send(input logic [7:0] b, input logic a, input logic e);
      @(posedge clk);
      #1 atn = a;
      dio = b;
      eoi = e;
      nrfd = 1'b0;
      ndac = 1'b0;
      repeat (lag + 1) @(posedge clk); // settle time
      do @(posedge clk); while (nrfdIn !== 1'b0);
      #1 dav = 1'b1;
      do @(posedge clk); while (ndacIn !== 1'b0);
      #1 dav = 1'b0;
      dio = 8'h00; // released lines read false
      eoi = 1'b0;
   endtask : send
   // accept one byte from the talker, attention off
   task automatic recv();
      @(posedge clk);
      #1 atn = 1'b0;
      ndac = 1'b1;
      nrfd = 1'b1;
      repeat (lag) @(posedge clk);
      #1 nrfd = 1'b0;
      do @(posedge clk); while (davIn !== 1'b1);
      #1 nrfd = 1'b1;
      ndac = 1'b0;
      do @(posedge clk); while (davIn !== 1'b0);
      #1 ndac = 1'b1;
   endtask : recv
endmodule : ibd_ctl_model

// *** tb.sv ***
// self-checking bench for the device end of the instrument bus
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   // ----
   // signals and wired bus
   // ----
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [4:0] primaryAddr = 5'h10; // own address 16
   logic [7:0] statusByte = 8'h00;
   logic ifcIn = 1'b0;
   logic renIn = 1'b0;
   logic svcReq = 1'b0;
   logic [7:0] txData = 8'h00;
   logic txEnd = 1'b0;
   logic txValid = 1'b0;
   logic rxReady = 1'b0;
   logic stall = 1'b0; // holds the receiver off
   logic davWas = 1'b0;
   logic atnIn, cDav, cEoi, cNrfd, cNdac;
   logic [7:0] cDio, dioOut, rxData;
   logic dioOe, davOut, davOe, nrfdOut, nrfdOe, ndacOut, ndacOe, eoiOut, eoiOe, srqOut, srqOe;
   logic txReady, rxEnd, rxValid, listenActive, talkActive, remoteMode, lockoutMode, devClear, trigger;
   logic [10:0] expQ[$]; // kind, end flag, byte
   logic [7:0] word[4] = '{8'h2a, 8'h52, 8'h53, 8'h54};
   int mismatches = 0;
   int n_checks = 0;
   // open-collector lines: true wins
   wire logic [7:0] dioIn = cDio | (dioOe ? dioOut : 8'h00);
   wire logic davIn = cDav | (davOe & davOut);
   wire logic nrfdIn = cNrfd | (nrfdOe & nrfdOut);
   wire logic ndacIn = cNdac | (ndacOe & ndacOut);
   wire logic eoiIn = cEoi | (eoiOe & eoiOut);
   always #4 clk = ~clk;
   ibd_device dut (.clk, .rst_n, .primaryAddr, .dioIn, .dioOut, .dioOe, .atnIn, .ifcIn, .renIn, .davIn, .davOut,
      .davOe, .nrfdIn, .nrfdOut, .nrfdOe, .ndacIn, .ndacOut, .ndacOe, .eoiIn, .eoiOut, .eoiOe, .srqOut, .srqOe,
      .svcReq, .statusByte, .txData, .txEnd, .txValid, .txReady, .rxData, .rxEnd, .rxValid, .rxReady,
      .listenActive, .talkActive, .remoteMode, .lockoutMode, .devClear, .trigger);
   ibd_ctl_model ctl (.clk, .nrfdIn, .ndacIn, .davIn, .atn(atnIn), .dav(cDav), .eoi(cEoi), .dio(cDio),
      .nrfd(cNrfd), .ndac(cNdac));
   // ----
   // tasks
   // ----
   task automatic chk(input logic [10:0] got, input logic [10:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: saw %h, expected %h", $time, got, exp);
      end
   endtask : chk
   // take the oldest note for a result that appeared
   task automatic see(input logic [10:0] got);
      if (expQ.size() == 0) begin
         mismatches++;
         $display("Error at %0t: unexpected result %h", $time, got);
      end else chk(got, expQ.pop_front());
   endtask : see
   task automatic cmd(input logic [7:0] b);
      ctl.send(b, 1'b1, 1'b0);
   endtask : cmd
   // address state checked three cycles after the byte
   task automatic lvl(input logic l, input logic t);
      repeat (3) @(posedge clk);
      #1 chk({9'h000, listenActive, talkActive}, {9'h000, l, t});
   endtask : lvl
   task automatic print_verdict();
      if (mismatches == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : print_verdict
   // ----
   // receiver readiness and result monitor
   // ----
   always @(posedge clk) rxReady <= #1 stall ? 1'b0 : 1'($urandom_range(0, 1));
   always @(posedge clk) begin
      if (rxValid === 1'b1 && rxReady === 1'b1) see({2'b00, rxEnd, rxData});
      if (devClear === 1'b1) see(11'h200);
      if (trigger === 1'b1) see(11'h400);
      if (davOe === 1'b1 && !davWas) see({2'b11, eoiIn, dioIn});
      davWas = (davOe === 1'b1);
   end
   // watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      print_verdict();
   end
   // ----
   // main sequence
   // ----
   initial begin
      logic [7:0] b;
      void'($urandom(32'hcb66));
      repeat (6) @(posedge clk);
      #1 rst_n = 1'b1;
      lvl(1'b0, 1'b0);
      renIn = 1'b1;
      cmd(8'h3f);
      cmd(8'h04);
      cmd(8'h08);
      cmd(8'h30);
      lvl(1'b1, 1'b0);
      chk({10'h000, remoteMode}, 11'h001);
      expQ.push_back(11'h200);
      cmd(8'h04);
      expQ.push_back(11'h400);
      cmd(8'h08);
      cmd(8'h05);
      ctl.send(8'h61, 1'b1, 1'b1);
      lvl(1'b1, 1'b0);
      stall = 1'b1;
      fork
         foreach (word[i]) begin
            expQ.push_back({2'b00, (i == 3), word[i]});
            ctl.send(word[i], 1'b0, (i == 3));
         end
         begin
            repeat (60) @(posedge clk);
            #1 chk({10'h000, nrfdOe}, 11'h001);
            stall = 1'b0;
         end
      join
      repeat (4) begin
         ctl.lag = $urandom_range(0, 3);
         b = 8'($urandom);
         expQ.push_back({3'b000, b});
         ctl.send(b, 1'b0, 1'b0);
      end
      cmd(8'h11);
      cmd(8'h01);
      repeat (3) @(posedge clk);
      #1 chk({9'h000, remoteMode, lockoutMode}, 11'h001);
      cmd(8'h3f);
      lvl(1'b0, 1'b0);
      ctl.send(8'h55, 1'b0, 1'b0);
      cmd(8'h50);
      lvl(1'b0, 1'b1);
      fork
         for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            #1 txData = 8'($urandom);
            txEnd = (k == 2);
            txValid = 1'b1;
            expQ.push_back({2'b11, txEnd, txData});
            do @(posedge clk); while (txReady !== 1'b1);
            #1 txValid = 1'b0;
         end
         repeat (3) ctl.recv();
      join
      statusByte = 8'($urandom);
      svcReq = 1'b1;
      cmd(8'h18);
      expQ.push_back({2'b11, 1'b0, statusByte[7], 1'b1, statusByte[5:0]});
      ctl.recv();
      cmd(8'h19);
      svcReq = 1'b0;
      cmd(8'h30);
      lvl(1'b1, 1'b0);
      cmd(8'h50);
      lvl(1'b0, 1'b1);
      cmd(8'h5f);
      lvl(1'b0, 1'b0);
      expQ.push_back(11'h200);
      cmd(8'h14);
      cmd(8'h30);
      @(posedge clk);
      #1 ifcIn = 1'b1;
      repeat (2) @(posedge clk);
      #1 ifcIn = 1'b0;
      lvl(1'b0, 1'b0);
      renIn = 1'b0;
      svcReq = 1'b1;
      repeat (4) @(posedge clk);
      #1 chk({8'h00, remoteMode, srqOe, srqOut}, 11'h003);
      svcReq = 1'b0;
      repeat (4) @(posedge clk);
      chk(11'(expQ.size()), 11'h000);
      print_verdict();
   end
endmodule : tb
